//--- rtl/pidsr_pkg.sv
// Package for the speed reference PID controller
package pidsr_pkg;
	localparam int DATA_W = 16;
	localparam int ACC_W = 32;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_KP = 8'h04;
	localparam logic [7:0] ADDR_KI = 8'h08;
	localparam logic [7:0] ADDR_KD = 8'h0c;
	localparam logic [7:0] ADDR_BIAS = 8'h10;
	localparam logic [7:0] ADDR_ILIM = 8'h14;
	localparam logic [7:0] ADDR_OLIM = 8'h18;
	localparam logic [7:0] ADDR_LAG = 8'h1c;
	localparam logic [7:0] ADDR_OUT = 8'h20;
	localparam logic [7:0] ADDR_STAT = 8'h24;
	// Control bit positions
	localparam int CTRL_FB_SEL = 0;
	localparam int CTRL_TGT_SEL = 1;
	localparam int CTRL_ADD_MODE = 2;
	localparam int CTRL_ENABLE = 3;
	localparam int CTRL_W = 4;
	// Current input offset for 4 mA (20 % of full scale of 16 bits)
	localparam logic signed [DATA_W:0] MA4_OFFSET = 17'sh03333;
	localparam logic [15:0] MA_SCALE_NUM = 16'h5000;
	localparam int MA_SCALE_SH = 14;
	localparam int GAIN_SH = 8;
	localparam int LAG_SH = 8;
	localparam int SAMPLE_US = 1000;
	localparam int CLK_MHZ = 10;
	localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
	typedef struct packed {
		logic [15:0] kp;
		logic [15:0] ki;
		logic [15:0] kd;
		logic [15:0] bias;
		logic [15:0] ilim;
		logic [15:0] olim;
		logic [7:0] lag;
		logic [CTRL_W-1:0] ctrl;
	} pidsr_cfg_t;
endpackage

//--- rtl/pidsr_top.sv
// Speed reference PID controller with APB registers
//
// Function
// - Error is selected target minus selected feedback, and all terms use it.
// - Result replaces the frequency reference or is added onto it, per mode bit.
// - Target comes from the operator command or the analog auxiliary input.
// - Feedback is the 4-20 mA current input or the 0-10 V voltage input, scaled.
// - Proportional term is error times proportional gain.
// - Integral accumulates error scaled by inverse integral time; zero disables it.
// - Integral term is clamped to plus or minus the integral limit.
// - Derivative term is error change times derivative time; zero disables it.
// - Output is clamped symmetrically to the output limit.
// - Integrator holds while the output is at the limit.
// - Bias is added as a fixed offset to the output.
// - Output passes a first-order lag set by the delay setting.
// - Feedback select zero picks voltage, one picks current.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pidsr_top #(
	parameter int SAMPLE_CYCLES = pidsr_pkg::SAMPLE_CYC
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic signed [pidsr_pkg::DATA_W-1:0] operator_command,
	input wire logic signed [pidsr_pkg::DATA_W-1:0] aux_analog_input,
	input wire logic [pidsr_pkg::DATA_W-1:0] current_feedback_input,
	input wire logic [pidsr_pkg::DATA_W-1:0] voltage_feedback_input,
	input wire logic signed [pidsr_pkg::DATA_W-1:0] speed_reference_in,
	output logic signed [pidsr_pkg::DATA_W-1:0] freq_reference_out
);
	import pidsr_pkg::*;
	// Timer needs at least two states between updates
	if (SAMPLE_CYCLES < 2) begin : g_bad_sample
		$error("SAMPLE_CYCLES too small");
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers
	pidsr_cfg_t cfg_r, cfg_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pslverr_r, pslverr_nxt;
	logic pready_r, pready_nxt;
	logic signed [DATA_W-1:0] pid_out_r;
	logic sat_r;

	always_comb begin
		cfg_nxt = cfg_r;
		prdata_nxt = prdata_r;
		pslverr_nxt = 1'b0;
		pready_nxt = 1'b0;
		// No wait state: answer in the cycle after setup
		if (psel && !penable) begin
			pready_nxt = 1'b1;
			prdata_nxt = 32'h0;
			if (pwrite) begin
				case (paddr)
					ADDR_CTRL, ADDR_KP, ADDR_KI, ADDR_KD: pslverr_nxt = 1'b0;
					ADDR_BIAS, ADDR_ILIM, ADDR_OLIM, ADDR_LAG: pslverr_nxt = 1'b0;
					default: pslverr_nxt = 1'b1;
				endcase
			end else begin
				case (paddr)
					ADDR_CTRL: prdata_nxt = {28'h0, cfg_r.ctrl};
					ADDR_KP: prdata_nxt = {16'h0, cfg_r.kp};
					ADDR_KI: prdata_nxt = {16'h0, cfg_r.ki};
					ADDR_KD: prdata_nxt = {16'h0, cfg_r.kd};
					ADDR_BIAS: prdata_nxt = {16'h0, cfg_r.bias};
					ADDR_ILIM: prdata_nxt = {16'h0, cfg_r.ilim};
					ADDR_OLIM: prdata_nxt = {16'h0, cfg_r.olim};
					ADDR_LAG: prdata_nxt = {24'h0, cfg_r.lag};
					ADDR_OUT: prdata_nxt = {{16{pid_out_r[DATA_W-1]}}, pid_out_r};
					ADDR_STAT: prdata_nxt = {31'h0, sat_r};
					default: pslverr_nxt = 1'b1;
				endcase
			end
		end
		// Write lands only at the edge where pready is sampled high
		if (psel && penable && pready_r && pwrite && !pslverr_r) begin
			case (paddr)
				ADDR_CTRL: cfg_nxt.ctrl = pwdata[CTRL_W-1:0];
				ADDR_KP: cfg_nxt.kp = pwdata[15:0];
				ADDR_KI: cfg_nxt.ki = pwdata[15:0];
				ADDR_KD: cfg_nxt.kd = pwdata[15:0];
				ADDR_BIAS: cfg_nxt.bias = pwdata[15:0];
				ADDR_ILIM: cfg_nxt.ilim = pwdata[15:0];
				ADDR_OLIM: cfg_nxt.olim = pwdata[15:0];
				ADDR_LAG: cfg_nxt.lag = pwdata[7:0];
				default: cfg_nxt = cfg_r;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cfg_r <= '0;
			prdata_r <= 32'h0;
			pslverr_r <= 1'b0;
			pready_r <= 1'b0;
		end else if (clk_en) begin
			cfg_r <= cfg_nxt;
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
			pready_r <= pready_nxt;
		end
	end
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	////////////////////////////////////////////////////////////////////////////
	// Input selection
	logic signed [DATA_W:0] target, feedback, cur_lin, err;
	logic signed [DATA_W+16:0] cur_prod;
	always_comb begin
		target = cfg_r.ctrl[CTRL_TGT_SEL] ? 17'(aux_analog_input) : 17'(operator_command);
		// 4 mA offset removed, span rescaled
		cur_lin = $signed({1'b0, current_feedback_input}) - MA4_OFFSET;
		if (cur_lin < 0) cur_lin = '0;
		cur_prod = (DATA_W+17)'(cur_lin * $signed({1'b0, MA_SCALE_NUM}));
		feedback = cfg_r.ctrl[CTRL_FB_SEL] ? 17'(cur_prod >>> MA_SCALE_SH)
			: $signed({1'b0, voltage_feedback_input});
		err = 17'(target - feedback);
	end

	////////////////////////////////////////////////////////////////////////////
	// Sample timer and PID datapath
	logic [31:0] tick_cnt_r, tick_cnt_nxt;
	logic tick;
	logic signed [ACC_W-1:0] integ_r, integ_nxt;
	logic signed [DATA_W:0] prev_err_r, prev_err_nxt;
	logic signed [ACC_W-1:0] lag_r, lag_nxt;
	logic signed [DATA_W-1:0] pid_out_nxt, freq_r, freq_nxt;
	logic sat_nxt;
	logic signed [ACC_W-1:0] p_term, i_term, d_term, sum, ilim, olim, integ_try, filt;

	always_comb begin
		tick = (tick_cnt_r == 32'(SAMPLE_CYCLES - 1));
		tick_cnt_nxt = tick ? 32'h0 : tick_cnt_r + 32'h1;
		ilim = ACC_W'($signed({1'b0, cfg_r.ilim}));
		olim = ACC_W'($signed({1'b0, cfg_r.olim}));
		p_term = ACC_W'((err * $signed({1'b0, cfg_r.kp})) >>> GAIN_SH);
		// integral step inverse to time, off at zero
		integ_try = integ_r;
		if (cfg_r.ki != 16'h0) integ_try = integ_r + ACC_W'(ACC_W'(err) / $signed({1'b0, cfg_r.ki}));
		if (integ_try > ilim) integ_try = ilim;
		if (integ_try < -ilim) integ_try = -ilim;
		i_term = (cfg_r.ki == 16'h0) ? '0 : integ_r;
		// rate of error change, off at zero
		d_term = (cfg_r.kd == 16'h0) ? '0
			: ACC_W'(((err - prev_err_r) * $signed({1'b0, cfg_r.kd})) >>> GAIN_SH);
		sum = p_term + i_term + d_term + ACC_W'($signed({1'b0, cfg_r.bias}));
		sat_nxt = (sum >= olim) || (sum <= -olim);
		if (sum > olim) sum = olim;
		if (sum < -olim) sum = -olim;
		integ_nxt = (sat_nxt || cfg_r.ki == 16'h0) ? integ_r : integ_try;
		prev_err_nxt = err;
		// first-order lag, larger setting is slower
		// Signed divisor keeps negative steps signed
		filt = lag_r + ((ACC_W'(sum <<< LAG_SH) - lag_r) / $signed(ACC_W'({1'b0, cfg_r.lag} + 9'h1)));
		lag_nxt = filt;
		pid_out_nxt = DATA_W'(filt >>> LAG_SH);
		freq_nxt = cfg_r.ctrl[CTRL_ADD_MODE] ? DATA_W'(speed_reference_in + pid_out_nxt) : pid_out_nxt;
		if (!cfg_r.ctrl[CTRL_ENABLE]) freq_nxt = speed_reference_in;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt_r <= 32'h0;
			integ_r <= '0;
			prev_err_r <= '0;
			lag_r <= '0;
			pid_out_r <= '0;
			sat_r <= 1'b0;
			freq_r <= '0;
		end else if (clk_en && tick) begin
			tick_cnt_r <= tick_cnt_nxt;
			integ_r <= integ_nxt;
			prev_err_r <= prev_err_nxt;
			lag_r <= lag_nxt;
			pid_out_r <= pid_out_nxt;
			sat_r <= sat_nxt;
			freq_r <= freq_nxt;
		end else if (clk_en) begin
			tick_cnt_r <= tick_cnt_nxt;
		end
	end
	assign freq_reference_out = freq_r;
endmodule
`default_nettype wire

//--- tb/pidsr_props.sv
// Port checker for the PID controller
`timescale 1ns/1ps
`default_nettype none
module pidsr_props #(
	parameter int SAMPLE_CYCLES = 8
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic signed [pidsr_pkg::DATA_W-1:0] freq_reference_out
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	wire setup = psel && !penable;
	chk_ready_wait: assert property (setup |=> pready) else $error("no ready");
	chk_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
	chk_err_ready: assert property (pslverr |-> pready) else $error("lone error");
	chk_ro_refused: assert property (setup && pwrite && paddr == 8'h20 |=> pslverr) else $error("ro write");
	chk_unmapped_err: assert property (setup && paddr > 8'h24 |=> pslverr) else $error("unmapped");
	chk_read_ok: assert property (setup && !pwrite && paddr <= 8'h24 && paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("read refused");
	chk_freeze_hold: assert property (!clk_en |=> $stable(freq_reference_out)) else $error("moved");
	// No change in the three cycles after a change
	chk_sample_spacing: assert property ($changed(freq_reference_out) |=> $stable(freq_reference_out)[*3])
		else $error("early update");
	cov_write: cover property (setup && pwrite);
	cov_err: cover property (pslverr);
	cov_update: cover property ($changed(freq_reference_out));
endmodule
`default_nettype wire

//--- tb/pidsr_far_model.sv
// Drive side: speed reference and analog feedback
`timescale 1ns/1ps
`default_nettype none
module pidsr_far_model (
	input wire logic clk_sys,
	input wire logic signed [15:0] sref_set,
	output logic signed [15:0] speed_reference_in,
	output logic [15:0] current_feedback_input,
	output logic [15:0] voltage_feedback_input
);
	// Feedback held at zero process value: 4 mA and 0 V
	always_ff @(posedge clk_sys) begin
		speed_reference_in <= sref_set;
		current_feedback_input <= 16'h3333;
		voltage_feedback_input <= 16'h0000;
	end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the PID controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pidsr_pkg::*;
	localparam int SC = 8;
	logic clk_sys = 0, reset_n = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic signed [15:0] operator_command = 0, aux_analog_input = 0, sref_set = 0, speed_reference_in;
	logic signed [15:0] freq_reference_out, hold;
	logic [15:0] current_feedback_input, voltage_feedback_input;
	int fails = 0, compares = 0, a, b;
	always #50 clk_sys = ~clk_sys;
	pidsr_top #(.SAMPLE_CYCLES(SC)) dut (.clk_sys, .reset_n, .clk_en, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .operator_command, .aux_analog_input, .current_feedback_input,
		.voltage_feedback_input, .speed_reference_in, .freq_reference_out);
	pidsr_far_model far (.clk_sys, .sref_set, .speed_reference_in, .current_feedback_input,
		.voltage_feedback_input);
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task chk(input string n, input logic [31:0] x, input logic [31:0] s);
		compares++;
		if (s !== x) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, x, s);
		end
	endtask
	task run(input logic [3:0] c, input int cmd, aux, sr, lim, bias);
		int t;
		apb(1, ADDR_CTRL, {28'h0, c});
		apb(1, ADDR_OLIM, lim);
		apb(1, ADDR_BIAS, bias);
		operator_command <= 16'(cmd);
		aux_analog_input <= 16'(aux);
		sref_set <= 16'(sr);
		repeat (3 * SC) @(posedge clk_sys);
		t = (c[CTRL_TGT_SEL] ? aux : cmd) + bias;
		t = t > lim ? lim : (t < -lim ? -lim : t);
		t = !c[CTRL_ENABLE] ? sr : (c[CTRL_ADD_MODE] ? sr + t : t);
		chk("freq_reference_out", 32'(t), 32'(freq_reference_out));
	endtask
	task conclude;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (8000) @(posedge clk_sys);
		fails++;
		conclude;
	end
	initial begin
		void'($urandom(32'h86f4));
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		chk("out after reset", 32'h0, 32'(freq_reference_out));
		apb(1, ADDR_KP, 32'h100);
		apb(0, ADDR_KP, 32'h0);
		chk("kp", 32'h100, q);
		apb(1, ADDR_OUT, 32'h5);
		chk("ro write err", 32'h1, 32'(e));
		apb(0, 8'h30, 32'h0);
		chk("unmapped err", 32'h1, 32'(e));
		for (int i = 0; i < 4; i++) begin
			a = $urandom_range(1000);
			b = $urandom_range(1000);
			run(4'h0, a, b, b, 32767, 0);
			run(4'h8, a, b, b, 32767, 0);
			run(4'ha, -a, b, b, 32767, 16);
			run(4'hc, a, b, -b, 32767, 0);
			run(4'h9, b, a, a, 32767, 0);
			run(4'h8, -a - 200, b, b, 150, 0);
		end
		apb(1, ADDR_KP, 32'h0);
		apb(1, ADDR_OLIM, 32767);
		apb(1, ADDR_ILIM, 100);
		operator_command <= 16'sd50;
		apb(1, ADDR_KI, 32'h1);
		repeat (6 * SC) @(posedge clk_sys);
		chk("integral clamp", 32'd100, 32'(freq_reference_out));
		apb(1, ADDR_OLIM, 60);
		repeat (3 * SC) @(posedge clk_sys);
		chk("output clamp", 32'd60, 32'(freq_reference_out));
		apb(0, ADDR_STAT, 32'h0);
		chk("saturated", 32'h1, q);
		apb(1, ADDR_OLIM, 32767);
		apb(1, ADDR_KI, 32'h0);
		apb(1, ADDR_KD, 32'h100);
		repeat (3 * SC) @(posedge clk_sys);
		chk("steady derivative", 32'h0, 32'(freq_reference_out));
		hold = freq_reference_out;
		clk_en <= 1'b0;
		operator_command <= 16'sh0100;
		repeat (3 * SC) @(posedge clk_sys);
		chk("frozen out", 32'(hold), 32'(freq_reference_out));
		clk_en <= 1'b1;
		conclude;
	end
endmodule
bind pidsr_top pidsr_props #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) props (.clk_sys, .reset_n, .clk_en, .psel,
	.penable, .pwrite, .paddr, .pready, .pslverr, .freq_reference_out);
`default_nettype wire
